// ==== tb.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Self-checking bench for the channel grouping block
// ---------------------------------------------------------------------------
module tb;
  import timer_group_pkg::*;

  logic               core_clk            = 1'b0;
  logic               rst_n               = 1'b0;
  logic               unit_run            = 1'b0;
  logic [7:0]         cfg_master_req      = 8'h00;
  logic [7:0]         cfg_slave_req       = 8'h00;
  logic [7:0]         master_link_select  = 8'h00;
  logic [8*CNT_W-1:0] cfg_period          = '0;
  logic               channel_timer_input = 1'b0;
  logic               channel_timer_output;
  logic               group_running;
  logic               group_fault;
  logic [7:0]         master_event;
  logic [7:0]         slave_event;
  logic [23:0]        chan_owner;
  int                 bad_count = 0;
  int                 tests_run = 0;
  int                 seed      = 87;
  int                 cyc       = 0;
  int                 last_hit  = -1;
  int                 gap       = 0;
  int                 per;
  logic               watch     = 1'b0;
  logic               s_pend    = 1'b0;
  logic [7:0]         s_due     = 8'h00;
  logic               prev;
  logic [7:0]         mq[$];
  logic [7:0]         sq[$];
  // Bad groupings: odd master, unlinked even master, slave on zero,
  // a channel that is both, and a slave whose head is no master.
  logic [7:0] m_t[5] = '{8'h09, 8'h05, 8'h01, 8'h05, 8'h01};
  logic [7:0] s_t[5] = '{8'h00, 8'h00, 8'h01, 8'h04, 8'h08};
  logic [7:0] l_t[5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04};
  // Slave channels of the legal grouping and their expected owners.
  int         ch_l[5]  = '{1, 3, 5, 6, 7};
  logic [2:0] own_l[5] = '{3'h0, 3'h2, 3'h4, 3'h4, 3'h4};

  // Free-running 50 MHz clock.
  always #10 core_clk = ~core_clk;

  timer_channel_group #(.CNT_W(CNT_W)) timer_channel_group_inst (
    .core_clk(core_clk), .rst_n(rst_n), .unit_run(unit_run),
    .cfg_master_req(cfg_master_req), .cfg_slave_req(cfg_slave_req),
    .master_link_select(master_link_select), .cfg_period(cfg_period),
    .channel_timer_input(channel_timer_input),
    .channel_timer_output(channel_timer_output),
    .group_running(group_running), .group_fault(group_fault),
    .master_event(master_event), .slave_event(slave_event),
    .chan_owner(chan_owner));

  // ---------------------------------------------------------------------------
  // Compare and verdict tasks
  // ---------------------------------------------------------------------------
  task automatic bad(input string msg);
    bad_count++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad

  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp,
                         input string msg);
    tests_run++;
    if (got !== exp) bad(msg);
  endtask : chk_vec

  task automatic chk_flag(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) bad(msg);
  endtask : chk_flag

  task automatic chk_owner(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) bad("owner mismatch");
  endtask : chk_owner

  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask : ticks

  // Grouping is applied whole at one edge so no half setting is seen.
  task automatic cfg(input logic [7:0] m, input logic [7:0] s,
                     input logic [7:0] l);
    @(posedge core_clk);
    cfg_master_req     <= m;
    cfg_slave_req      <= s;
    master_link_select <= l;
  endtask : cfg

  // ---------------------------------------------------------------------------
  // Monitor: takes the oldest note whenever a master event shows up while watch is set
  // ---------------------------------------------------------------------------
  // Sampled on the falling edge, where registered pulses have settled.
  always @(negedge core_clk) begin
    cyc++;
    if (s_pend) begin
      chk_vec(slave_event, s_due, "slave event");
      s_pend = 1'b0;
    end
    if (watch && master_event !== 8'h00) begin
      if (mq.size() == 0) begin
        bad("unexpected event");
      end else begin
        chk_vec(master_event, mq.pop_front(), "master event");
        s_due  = sq.pop_front();
        s_pend = 1'b1;
        if (last_hit >= 0) chk_vec(8'(cyc - last_hit), 8'(gap), "period");
        last_hit = cyc;
      end
    end
  end

  // A hang counts as a mismatch and ends the run.
  initial begin
    #200000;
    bad("timeout");
    tally_and_finish();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    ticks(8);
    chk_vec(master_event, 8'h00, "reset event");
    ticks(8);
    rst_n <= 1'b1;
    // Masters 0, 2, 4; odd link bits must be ignored.
    per = 3 + ($random(seed) & 7);
    for (int i = 0; i < 8; i++) cfg_period[i*CNT_W +: CNT_W] <= CNT_W'(per);
    cfg(8'h15, 8'hea, 8'h3f);
    gap = per + 1;
    repeat (6) begin
      mq.push_back(8'h15);
      sq.push_back(8'hea);
    end
    watch = 1'b1;
    @(posedge core_clk);
    unit_run <= 1'b1;
    ticks(2);
    #1 chk_flag(group_running, 1'b1, "legal refused");
    chk_flag(group_fault, 1'b0, "legal faulted");
    for (int k = 0; k < 5; k++) chk_owner(chan_owner[3*ch_l[k] +: 3], own_l[k]);
    for (int t = 0; t < 300 && mq.size() > 0; t++) @(posedge core_clk);
    chk_vec(8'(mq.size()), 8'h00, "events missing");
    ticks(2);
    watch = 1'b0;
    unit_run <= 1'b0;
    // Each bad grouping must be refused.
    for (int i = 0; i < 5; i++) begin
      cfg(m_t[i], s_t[i], l_t[i]);
      @(posedge core_clk);
      unit_run <= 1'b1;
      ticks(2);
      #1 chk_flag(group_fault, 1'b1, "bad grouping accepted");
      chk_flag(group_running, 1'b0, "bad grouping running");
      @(posedge core_clk);
      unit_run <= 1'b0;
      ticks(2);
      #1 chk_flag(group_fault, 1'b0, "fault held");
    end
    // Channel six on its own: its input pin edge toggles its output pin.
    cfg_period[6*CNT_W +: CNT_W] <= '1;
    cfg(8'h01, 8'h02, 8'h00);
    @(posedge core_clk);
    unit_run <= 1'b1;
    repeat (2) begin
      ticks(3);
      #1 prev = channel_timer_output;
      @(posedge core_clk);
      channel_timer_input <= 1'b1;
      ticks(1 + ($random(seed) & 3));
      channel_timer_input <= 1'b0;
      ticks(8);
      #1 chk_flag(channel_timer_output, ~prev, "pin toggle");
    end
    tally_and_finish();
  end

endmodule : tb

// ==== timer_channel_group.sv ====
`timescale 1ns/1ps
module timer_channel_group #(
  parameter int CNT_W = timer_group_pkg::CNT_W
) (
  // Clock and reset.
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // Configuration from software logic on the same clock.
  input  wire logic                    unit_run,
  input  wire logic [7:0]              cfg_master_req,
  input  wire logic [7:0]              cfg_slave_req,
  input  wire logic [7:0]              master_link_select,
  input  wire logic [8*CNT_W-1:0]      cfg_period,
  // External pins of channel six.
  input  wire logic                    channel_timer_input,
  output logic                         channel_timer_output,
  // Status.
  output logic                         group_running,
  output logic                         group_fault,
  output logic [7:0]                   master_event,
  output logic [7:0]                   slave_event,
  output logic [23:0]                  chan_owner
);
  import timer_group_pkg::*;

  // -------------------------------------------------------------------------
  // Grouping decode
  // -------------------------------------------------------------------------

  // Finds the nearest lower channel that heads a group.
  function automatic logic [2:0] owner_of(input int ch,
                                          input logic [7:0] head);
    owner_of = 3'h0;
    for (int j = 0; j < 8; j++) begin
      if (j < ch && head[j]) begin
        owner_of = 3'(j);
      end
    end
  endfunction : owner_of

  // Group heads: channel zero, plus linked even channels.
  wire logic [7:0] head = FIRST_HEAD |
                          (master_link_select & LINK_CHANNELS);
  // Owner of each channel, packed three bits per channel.
  logic [23:0] owner_w;
  // Slave requests that break the grouping.
  logic [7:0]  slave_bad;

  // Each channel looks down to its nearest head; a head between
  // hides any lower master, which keeps groups disjoint.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      owner_w[3*i +: 3] = owner_of(i, head);
      slave_bad[i] = cfg_slave_req[i] &
                     (~SLAVE_ELIGIBLE[i] |
                      ~cfg_master_req[owner_of(i, head)] |
                      cfg_master_req[i]);
    end
  end

  // A master request is legal only on an even head.
  wire logic master_bad = |(cfg_master_req &
                            ~(MASTER_ELIGIBLE & head));
  // The whole grouping is legal when no channel objects.
  wire logic grouping_ok = ~master_bad & ~|slave_bad;

  // -------------------------------------------------------------------------
  // Unit state
  // -------------------------------------------------------------------------

  // Current and next unit state.
  unit_state_e state;
  unit_state_e next_state;

  // A bad grouping stops all counting until software drops the run
  // request; resuming silently could leave slaves tied to a wrong head.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (unit_run) begin
          next_state = grouping_ok ? ST_RUN : ST_FAULT;
        end
      end
      ST_RUN: begin
        if (!unit_run) begin
          next_state = ST_IDLE;
        end else if (!grouping_ok) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (!unit_run) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counting is allowed only while the grouping is legal and running.
  wire logic running = (state == ST_RUN);

  // -------------------------------------------------------------------------
  // Master counters
  // -------------------------------------------------------------------------

  // One down-counter per channel; only masters use theirs.
  logic [CNT_W-1:0] cnt [8];
  // Terminal count of each master counter.
  logic [7:0]       cnt_zero;

  // The master counts its period down and reloads at zero, so a
  // period value P gives one event every P+1 cycles.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cnt_zero[i] = running & cfg_master_req[i] &
                    (cnt[i] == '0);
    end
  end

  // Counter registers, loaded from the period while not running.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!running || cnt_zero[i]) begin
          cnt[i] <= cfg_period[CNT_W*i +: CNT_W];
        end else begin
          cnt[i] <= cnt[i] - 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Event routing
  // -------------------------------------------------------------------------

  // Slave event: the owner's registered master event, one cycle later.
  logic [7:0] next_slave;

  // Every slave of a head sees the same event, so one master can
  // drive any number of followers in the same cycle.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_slave[i] = running & cfg_slave_req[i] & SLAVE_ELIGIBLE[i] &
                      master_event[owner_w[3*i +: 3]];
    end
  end

  // Event and owner registers.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_event  <= EVENT_RST;
      slave_event   <= EVENT_RST;
      chan_owner    <= '0;
      group_running <= 1'b0;
      group_fault   <= 1'b0;
    end else begin
      master_event  <= cnt_zero;
      slave_event   <= next_slave;
      chan_owner    <= owner_w;
      group_running <= (next_state == ST_RUN);
      group_fault   <= (next_state == ST_FAULT);
    end
  end

  // -------------------------------------------------------------------------
  // Channel six pins
  // -------------------------------------------------------------------------

  // Two-stage synchroniser, then an edge detector on the second stage.
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  // Rising edge on the input pin, only used when channel six is free.
  wire logic pin_edge = pin_sync & ~pin_prev;
  wire logic six_free = ~cfg_master_req[PIN_CH] & ~cfg_slave_req[PIN_CH];
  // Toggle source for the output pin.
  wire logic six_hit  = master_event[PIN_CH] | slave_event[PIN_CH] |
                        (running & six_free & pin_edge);

  // The other channels have no pins; channel seven stays pinless too.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta             <= 1'b0;
      pin_sync             <= 1'b0;
      pin_prev             <= 1'b0;
      channel_timer_output <= PIN_OUT_RST;
    end else begin
      pin_meta             <= channel_timer_input;
      pin_sync             <= pin_meta;
      pin_prev             <= pin_sync;
      channel_timer_output <= channel_timer_output ^ six_hit;
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_master_even_only: assert property (
    (master_event & ~MASTER_ELIGIBLE) == 8'h00)
    else $error("master event on an odd channel");
  a_no_slave_zero: assert property (
    !slave_event[0])
    else $error("channel zero acted as slave");
  a_owner_below: assert property (
    chan_owner[23:21] < LAST_CH && chan_owner[5:3] == 3'h0)
    else $error("owner not below its slave");
  a_many_slaves: assert property (
    running && master_event[4] && cfg_slave_req[6:5] == 2'b11 &&
    head[4] && !head[6] ##1 running && $stable(cfg_slave_req)
    |-> slave_event[6:5] == 2'b11)
    else $error("master four failed to drive both slaves");
  a_nearest_head: assert property (
    $past(head[4]) && !$past(head[6]) |-> chan_owner[20:18] == 3'h4)
    else $error("channel six not owned by master four");
  a_link_channels: assert property (
    (head & 8'haa) == 8'h00)
    else $error("odd channel heads a group");
  a_pin_toggle: assert property (
    $changed(channel_timer_output) |-> $past(six_hit))
    else $error("pin toggled without a channel six event");
  a_period_gap: assert property (
    master_event[0] && cfg_period[CNT_W-1:0] != '0 |=> !master_event[0])
    else $error("master event repeated inside its period");
  a_slave_cause: assert property (
    slave_event != 8'h00 |-> $past(master_event) != 8'h00)
    else $error("slave event without a master event");
  a_bad_stops: assert property (
    running && !grouping_ok |=> group_fault && !running)
    else $error("illegal grouping kept running");

  c_two_groups: cover property (running && head[2] && head[4]);
  c_slave_fires: cover property (slave_event[3] && slave_event[5]);
  c_pin_edge: cover property (running && six_free && pin_edge);
  c_fault: cover property (group_fault);

endmodule : timer_channel_group

// ==== timer_group_pkg.sv ====
// ---------------------------------------------------------------------------
// Shared constants of the channel grouping block
// ---------------------------------------------------------------------------
package timer_group_pkg;

  // Number of channels and default counter width.
  localparam int NUM_CH = 8;
  localparam int CNT_W  = 16;

  // Channels that may lead a group: the even ones.
  localparam logic [7:0] MASTER_ELIGIBLE = 8'h55;
  // Channels that may follow a master: all but channel zero.
  localparam logic [7:0] SLAVE_ELIGIBLE  = 8'hfe;
  // Channels that carry the master-link select: two, four and six.
  localparam logic [7:0] LINK_CHANNELS   = 8'h54;
  // Channel zero always heads the first group.
  localparam logic [7:0] FIRST_HEAD      = 8'h01;
  // Only this channel has the external timer pins.
  localparam logic [2:0] PIN_CH          = 3'h6;
  // Channel seven is built outside the shared template.
  localparam logic [2:0] LAST_CH         = 3'h7;

  // Reset values.
  localparam logic [7:0] EVENT_RST       = 8'h00;
  localparam logic       PIN_OUT_RST     = 1'b0;

  // Unit state, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_FAULT = 3'b100
  } unit_state_e;

endpackage : timer_group_pkg
